// [rtl/twrt_target.sv]
/*
 * two-wire register target: framing, address match, paged register map,
 * and a four-wire side port into the same map.
 * assumes scl and sda arrive from the pins and are slow against pclk.
 */
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE_01] sda changes only while scl low
// [RULE_02] bytes of eight bits, msb first
// [RULE_03] detect start and stop conditions
// [RULE_04] acknowledge own address when enabled
// [RULE_05] single write: address, register, data, stop
// [RULE_06] host reads after setting register pointer
// [RULE_07] host ack advances pointer, next byte
// [RULE_08] missing register reads as zero
// [RULE_09] repeated start reuses same address
// [RULE_10] page write stores at incrementing addresses
// [RULE_11] repeated write alternates address and data
// [RULE_12] write mode change applies next frame
// [RULE_13] start or stop mid message aborts
// [RULE_14] auto auto_a clears page after access
// [RULE_15] bit six selects multi byte mode
// [RULE_16] two-wire page decode ignores lsb
// [RULE_17] four-wire page decode, four pages
// [RULE_18] write mode ignored on four-wire path
// [RULE_19] status reads show live signals
// [RULE_20] offset zero of each page controls
// [RULE_21] configurable address, default d0 d1
// [RULE_22] never stretch clock, no read delay
// [RULE_23] missing register writes acked, discarded
module twrt_target (
	input  wire logic               pclk,
	input  wire logic               presetn,
	twrt_if.target                  bus,
	input  wire twrt_pkg::twrt_byte_t status_a,
	input  wire twrt_pkg::twrt_byte_t status_b,
	input  wire logic               addr_sel,
	input  wire logic               fw_req,
	input  wire logic               fw_wr,
	input  wire logic [6:0]         fw_addr,
	input  wire twrt_pkg::twrt_byte_t fw_wdata,
	output twrt_pkg::twrt_byte_t    fw_rdata,
	output twrt_pkg::twrt_byte_t    page_control,
	output logic                    busy
);
	import twrt_pkg::*;
	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_ACK,
		S_RX,
		S_TX,
		S_MACK
	} twrt_tst_t;

	typedef struct packed {
		twrt_tst_t  st;
		logic [3:0] bitcnt;
		twrt_byte_t shift;
		twrt_byte_t ptr;
		logic       rw;
		logic       got_reg;
		logic       expect_addr;
		logic       rmode;
		logic       accessed;
		logic       sda_oe;
		logic       busy;
		logic       scl_q;
		logic       sda_q;
		twrt_byte_t page;
		twrt_byte_t cfg1;
		twrt_byte_t cfg2;
		twrt_byte_t altcfg;
		twrt_byte_t fw_rdata;
	} twrt_tstate_t;

	twrt_tstate_t s;
	twrt_tstate_t nxt_s;
	logic         scl_s;
	logic         sda_s;
	logic         sel_s;
	logic         scl_rise;
	logic         scl_fall;
	logic         start_c;
	logic         stop_c;
	logic         match;
	logic [3:0]   base;
	twrt_byte_t   rdv;

	twrt_sync u_scl (.pclk(pclk), .presetn(presetn), .d(bus.scl), .q(scl_s));
	twrt_sync u_sda (.pclk(pclk), .presetn(presetn), .d(bus.sda), .q(sda_s));
	twrt_sync u_sel (.pclk(pclk), .presetn(presetn), .d(addr_sel), .q(sel_s));
	function automatic twrt_addr_t map2(twrt_byte_t pg, twrt_byte_t a);
		twrt_addr_t r;
		r = BAD_ADDR;
		case (pg[PG_SEL_MSB -: 2]) // RULE_16
		PG2_LOW: r = {2'h0, a};
		PG2_MID: if (a < HALF_PAGE) r = A_PAGE2 + {2'h0, a};
		PG2_HIGH: if (a < HALF_PAGE) r = A_PAGE4 + {2'h0, a};
		default: r = BAD_ADDR;
		endcase
		return r;
	endfunction : map2

	function automatic twrt_addr_t map4(twrt_byte_t pg, logic [6:0] a);
		twrt_addr_t r;
		r = BAD_ADDR;
		case (pg[PG_SEL_MSB:0]) // RULE_17
		PG4_P0: r = A_PAGE0 + {3'h0, a};
		PG4_P1: r = A_PAGE1 + {3'h0, a};
		PG4_P2: r = A_PAGE2 + {3'h0, a};
		PG4_P4: r = A_PAGE4 + {3'h0, a};
		default: r = BAD_ADDR;
		endcase
		return r;
	endfunction : map4

	function automatic twrt_byte_t rd_reg(twrt_tstate_t t, twrt_addr_t a,
		twrt_byte_t sa, twrt_byte_t sb);
		twrt_byte_t r;
		r = 8'h00;
		case (a)
		A_PAGE0, A_PAGE1, A_PAGE2, A_PAGE4: r = t.page; // RULE_20
		A_STAT_A: r = sa; // RULE_19
		A_STAT_B: r = sb; // RULE_19
		A_CFG1: r = t.cfg1;
		A_CFG2: r = t.cfg2;
		A_ALTCFG: r = t.altcfg;
		default: r = 8'h00; // RULE_08
		endcase
		return r;
	endfunction : rd_reg

	function automatic twrt_tstate_t wr_reg(twrt_tstate_t t, twrt_addr_t a,
		twrt_byte_t d);
		twrt_tstate_t r;
		r = t;
		case (a)
		A_PAGE0, A_PAGE1, A_PAGE2, A_PAGE4: r.page = d & PG_MASK; // RULE_20
		A_CFG1: r.cfg1 = d;
		A_CFG2: r.cfg2 = d;
		A_ALTCFG: r.altcfg = d;
		default: r = t; // RULE_23
		endcase
		return r;
	endfunction : wr_reg

	assign scl_rise = scl_s & ~s.scl_q; // RULE_01
	assign scl_fall = ~scl_s & s.scl_q;
	assign start_c  = scl_s & s.scl_q & s.sda_q & ~sda_s; // RULE_03
	assign stop_c   = scl_s & s.scl_q & ~s.sda_q & sda_s; // RULE_03
	// alternate base only when enabled in config and strapped by the pin
	assign base = (s.altcfg[ADDR_SEL_BIT] & sel_s)
		? s.altcfg[BASE_MSB:BASE_LSB] : s.cfg1[BASE_MSB:BASE_LSB]; // RULE_21
	assign match = (s.shift[7:4] == base) && (s.shift[3:1] == 3'h0);
	// read byte fetched live at the scl edge that starts it
	assign rdv = rd_reg(s, map2(s.page, s.ptr), status_a, status_b); // RULE_22

	always_comb begin
		nxt_s = s;
		nxt_s.scl_q = scl_s;
		nxt_s.sda_q = sda_s;
		if (fw_req) begin
			// single-byte access: multi-byte write mode plays no part
			if (fw_wr) begin
				nxt_s = wr_reg(nxt_s, map4(s.page, fw_addr), fw_wdata); // RULE_18
			end else begin
				nxt_s.fw_rdata = rd_reg(s, map4(s.page, fw_addr),
					status_a, status_b);
			end
		end
		if (stop_c) begin
			nxt_s.st = S_IDLE; // RULE_13
			nxt_s.sda_oe = 1'b0;
			nxt_s.accessed = 1'b0;
			if (s.accessed && nxt_s.page[PG_AUTO_A]) begin
				nxt_s.page[PG_SEL_MSB:0] = 3'h0; // RULE_14
			end
		end else if (start_c) begin
			// also the repeated start: pointer survives, message restarts
			nxt_s.st = s.cfg2[IF_EN_BIT] ? S_ADDR : S_IDLE; // RULE_13
			nxt_s.bitcnt = 4'h0;
			nxt_s.sda_oe = 1'b0;
			nxt_s.got_reg = 1'b0;
			nxt_s.expect_addr = 1'b0;
			nxt_s.rmode = nxt_s.page[PG_WMODE]; // RULE_12
		end else begin
			case (s.st)
			S_ADDR, S_RX: begin
				if (scl_rise) begin
					nxt_s.shift = {s.shift[6:0], sda_s}; // RULE_02
					nxt_s.bitcnt = s.bitcnt + 4'h1;
				end else if (scl_fall && s.bitcnt == BITS_BYTE) begin
					nxt_s.bitcnt = 4'h0;
					nxt_s.st = S_ACK;
					nxt_s.sda_oe = 1'b1; // RULE_05
					if (s.st == S_ADDR) begin
						nxt_s.rw = s.shift[0];
						if (!match) begin
							nxt_s.st = S_IDLE;
							nxt_s.sda_oe = 1'b0;
						end else begin
							nxt_s.sda_oe = 1'b1; // RULE_04
						end
					end else if (!s.got_reg || s.expect_addr) begin
						nxt_s.ptr = s.shift; // RULE_11
						nxt_s.got_reg = 1'b1;
						nxt_s.expect_addr = 1'b0;
					end else begin
						nxt_s = wr_reg(nxt_s, map2(s.page, s.ptr), s.shift);
						nxt_s.accessed = 1'b1;
						if (s.rmode) begin
							nxt_s.expect_addr = 1'b1; // RULE_15
						end else begin
							nxt_s.ptr = s.ptr + 8'h01; // RULE_10
						end
					end
				end
			end
			S_ACK, S_MACK: begin
				if (scl_rise && s.st == S_MACK) begin
					if (!sda_s) begin
						nxt_s.ptr = s.ptr + 8'h01; // RULE_07
						nxt_s.bitcnt = ACK_MARK;
					end else begin
						nxt_s.st = S_IDLE;
					end
				end else if (scl_fall && (s.st == S_ACK
					|| s.bitcnt == ACK_MARK)) begin
					nxt_s.sda_oe = 1'b0;
					nxt_s.bitcnt = 4'h0;
					nxt_s.st = S_RX;
					if (s.rw) begin
						nxt_s.st = S_TX;
						nxt_s.shift = rdv;
						nxt_s.sda_oe = ~rdv[7]; // RULE_01
						nxt_s.accessed = 1'b1;
					end
				end
			end
			S_TX: begin
				if (scl_rise) begin
					nxt_s.bitcnt = s.bitcnt + 4'h1;
				end else if (scl_fall) begin
					if (s.bitcnt == BITS_BYTE) begin
						nxt_s.sda_oe = 1'b0;
						nxt_s.st = S_MACK;
						nxt_s.bitcnt = 4'h0;
					end else begin
						nxt_s.shift = {s.shift[6:0], 1'b0}; // RULE_02
						nxt_s.sda_oe = ~s.shift[6];
					end
				end
			end
			default: nxt_s.st = S_IDLE;
			endcase
		end
		nxt_s.busy = (nxt_s.st != S_IDLE);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{st: S_IDLE, scl_q: 1'b1, sda_q: 1'b1, page: PAGE_RST,
				cfg1: CFG1_RST, cfg2: CFG2_RST, altcfg: ALT_RST, default: '0};
		end else begin
			s <= nxt_s;
		end
	end

	// target never touches scl, so no stretching is possible
	assign bus.sda_tgt_oe = s.sda_oe; // RULE_22
	assign bus.sda_tgt_o  = 1'b0;
	assign fw_rdata       = s.fw_rdata;
	assign page_control   = s.page;
	assign busy           = s.busy;
endmodule : twrt_target
`default_nettype wire

// [rtl/twrt_pkg.sv]
/*
 * shared constants and types for the two-wire register target and its host.
 * assumes a single 40 mhz pclk domain on both ends.
 */
package twrt_pkg;
	typedef logic [7:0] twrt_byte_t;
	typedef logic [9:0] twrt_addr_t;

	localparam int CLK_NS        = 25;
	localparam int SCL_PERIOD_NS = 1000;
	localparam int QTR_CYC_I     = SCL_PERIOD_NS / 4 / CLK_NS;
	localparam logic [7:0] QTR_CYC = 8'(QTR_CYC_I);

	// full register addresses
	localparam twrt_addr_t A_PAGE0  = 10'h000;
	localparam twrt_addr_t A_PAGE1  = 10'h080;
	localparam twrt_addr_t A_PAGE2  = 10'h100;
	localparam twrt_addr_t A_PAGE4  = 10'h200;
	localparam twrt_addr_t A_STAT_A = 10'h050;
	localparam twrt_addr_t A_STAT_B = 10'h051;
	localparam twrt_addr_t A_CFG1   = 10'h105;
	localparam twrt_addr_t A_CFG2   = 10'h106;
	localparam twrt_addr_t A_ALTCFG = 10'h148;
	localparam twrt_addr_t BAD_ADDR = 10'h3ff;
	localparam twrt_byte_t HALF_PAGE = 8'h80;

	// page control fields
	localparam int PG_AUTO_A  = 7;
	localparam int PG_WMODE   = 6;
	localparam int PG_SEL_MSB = 2;
	localparam twrt_byte_t PG_MASK = 8'hc7;
	localparam logic [1:0] PG2_LOW  = 2'h0;
	localparam logic [1:0] PG2_MID  = 2'h1;
	localparam logic [1:0] PG2_HIGH = 2'h2;
	localparam logic [2:0] PG4_P0 = 3'h0;
	localparam logic [2:0] PG4_P1 = 3'h1;
	localparam logic [2:0] PG4_P2 = 3'h2;
	localparam logic [2:0] PG4_P4 = 3'h4;

	// configuration fields and reset values
	localparam int BASE_MSB    = 7;
	localparam int BASE_LSB    = 4;
	localparam int IF_EN_BIT   = 7;
	localparam int ADDR_SEL_BIT = 0;
	localparam twrt_byte_t PAGE_RST = 8'h00;
	localparam twrt_byte_t CFG1_RST = 8'hd0;
	localparam twrt_byte_t CFG2_RST = 8'h80;
	localparam twrt_byte_t ALT_RST  = 8'h90;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] ACK_MARK  = 4'h9;

	// host apb map
	localparam logic [7:0] H_CMD  = 8'h00;
	localparam logic [7:0] H_TXD  = 8'h04;
	localparam logic [7:0] H_STAT = 8'h08;
	localparam int ST_BUSY = 0;
	localparam int ST_ACK  = 1;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_START,
		CMD_WRITE,
		CMD_READ_ACK,
		CMD_READ_NACK,
		CMD_STOP
	} twrt_cmd_t;
endpackage : twrt_pkg

// [rtl/twrt_if.sv]
/*
 * two-wire link between host and target, open drain with pull-ups.
 * assumes each party drives low only through its enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface twrt_if;
	logic scl_drv_oe;
	logic scl_drv_o;
	logic sda_drv_oe;
	logic sda_drv_o;
	logic sda_tgt_oe;
	logic sda_tgt_o;
	logic scl;
	logic sda;

	// pulled high unless someone pulls low
	assign scl = ~(scl_drv_oe & ~scl_drv_o);
	assign sda = ~((sda_drv_oe & ~sda_drv_o) | (sda_tgt_oe & ~sda_tgt_o));

	modport target (
		input  scl,
		input  sda,
		output sda_tgt_oe,
		output sda_tgt_o
	);
	modport host (
		input  sda,
		output scl_drv_oe,
		output scl_drv_o,
		output sda_drv_oe,
		output sda_drv_o
	);
endinterface : twrt_if
`default_nettype wire

// [rtl/twrt_sync.sv]
/*
 * two flip-flop synchroniser for one pin.
 * assumes the pin idles high, so reset loads ones.
 */
`timescale 1ns/1ps
`default_nettype none
module twrt_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic d,
	output logic      q
);
	typedef struct packed {
		logic s1;
		logic s2;
	} twrt_sync_t;

	twrt_sync_t s;
	twrt_sync_t nxt_s;

	always_comb begin
		nxt_s = s;
		nxt_s.s1 = d;
		nxt_s.s2 = s.s1;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '1;
		end else begin
			s <= nxt_s;
		end
	end

	assign q = s.s2;
endmodule : twrt_sync
`default_nettype wire

// [rtl/twrt_host.sv]
/*
 * two-wire host: byte-level command engine under an apb slave.
 * assumes the target never stretches scl; scl is made here by a divider.
 */
`timescale 1ns/1ps
`default_nettype none
module twrt_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	twrt_if.host             bus,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	import twrt_pkg::*;

	typedef enum logic [1:0] {
		H_IDLE,
		H_START,
		H_BITS,
		H_STOP
	} twrt_hst_t;

	typedef struct packed {
		twrt_hst_t  st;
		logic [1:0] q;
		logic [7:0] tick;
		logic [3:0] bitn;
		logic [8:0] shift;
		twrt_byte_t rx;
		twrt_byte_t txd;
		logic       rd;
		logic       ackrx;
		logic       scl_oe;
		logic       sda_oe;
		logic       pready;
		logic       pslverr;
		logic [31:0] prdata;
	} twrt_hstate_t;

	twrt_hstate_t s;
	twrt_hstate_t nxt_s;
	logic         sda_s;
	logic         qen;
	twrt_cmd_t    cmd;

	twrt_sync u_sda (.pclk(pclk), .presetn(presetn), .d(bus.sda), .q(sda_s));

	assign qen = (s.tick == QTR_CYC - 8'h01);
	assign cmd = twrt_cmd_t'(pwdata[2:0]);

	always_comb begin
		nxt_s = s;
		nxt_s.pready = 1'b0;
		nxt_s.pslverr = 1'b0;
		// answer one cycle into the access phase
		if (psel && penable && !s.pready) begin
			nxt_s.pready = 1'b1;
			nxt_s.prdata = 32'h0;
			case (paddr)
			H_CMD: nxt_s.prdata = 32'h0;
			H_TXD: nxt_s.prdata = {24'h0, s.txd};
			H_STAT: nxt_s.prdata = {16'h0, s.rx, 6'h0, s.ackrx,
				s.st != H_IDLE};
			default: nxt_s.pslverr = 1'b1;
			endcase
		end
		if (s.st != H_IDLE) begin
			nxt_s.tick = qen ? 8'h00 : s.tick + 8'h01;
			if (qen) begin
				nxt_s.q = s.q + 2'h1;
				case (s.st)
				H_START: begin
					case (s.q)
					2'h0: nxt_s.sda_oe = 1'b0;
					2'h1: nxt_s.scl_oe = 1'b0;
					2'h2: nxt_s.sda_oe = 1'b1; // RULE_03
					default: begin
						nxt_s.scl_oe = 1'b1;
						nxt_s.st = H_IDLE;
					end
					endcase
				end
				H_BITS: begin
					case (s.q)
					2'h0: nxt_s.sda_oe = ~s.shift[8]; // RULE_01
					2'h1: nxt_s.scl_oe = 1'b0;
					2'h2: begin
						if (s.bitn == BITS_BYTE) begin
							if (!s.rd) nxt_s.ackrx = ~sda_s;
						end else if (s.rd) begin
							nxt_s.rx = {s.rx[6:0], sda_s}; // RULE_02
						end
					end
					default: begin
						nxt_s.scl_oe = 1'b1;
						nxt_s.shift = {s.shift[7:0], 1'b1};
						nxt_s.bitn = s.bitn + 4'h1;
						if (s.bitn == BITS_BYTE) nxt_s.st = H_IDLE;
					end
					endcase
				end
				H_STOP: begin
					case (s.q)
					2'h0: nxt_s.sda_oe = 1'b1;
					2'h1: nxt_s.scl_oe = 1'b0;
					2'h2: nxt_s.sda_oe = 1'b0; // RULE_03
					default: nxt_s.st = H_IDLE;
					endcase
				end
				default: nxt_s.st = H_IDLE;
				endcase
			end
		end
		// writes take effect at the edge that samples pready high
		if (psel && penable && s.pready && pwrite && !s.pslverr) begin
			if (paddr == H_TXD) nxt_s.txd = pwdata[7:0];
			if (paddr == H_CMD && s.st == H_IDLE && cmd != CMD_NONE) begin
				nxt_s.q = 2'h0;
				nxt_s.tick = 8'h00;
				nxt_s.bitn = 4'h0;
				nxt_s.rd = 1'b0;
				case (cmd)
				CMD_START: nxt_s.st = H_START; // RULE_09
				CMD_WRITE: begin
					nxt_s.st = H_BITS;
					nxt_s.shift = {s.txd, 1'b1}; // RULE_05
				end
				CMD_READ_ACK, CMD_READ_NACK: begin
					nxt_s.st = H_BITS;
					nxt_s.rd = 1'b1;
					// last byte must end with nack before stop
					nxt_s.shift = {8'hff, cmd == CMD_READ_NACK}; // RULE_06
				end
				CMD_STOP: nxt_s.st = H_STOP; // RULE_12
				default: nxt_s.st = H_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{st: H_IDLE, default: '0};
		end else begin
			s <= nxt_s;
		end
	end

	assign bus.scl_drv_oe = s.scl_oe;
	assign bus.scl_drv_o  = 1'b0;
	assign bus.sda_drv_oe = s.sda_oe;
	assign bus.sda_drv_o  = 1'b0;
	assign prdata         = s.prdata;
	assign pready         = s.pready;
	assign pslverr        = s.pslverr;
endmodule : twrt_host
`default_nettype wire

// [verif/twrt_chk.sv]
/* wire-level checker for the two-wire link between host and target.
   assumes both ends run on pclk and the link wires are pulled up. */
`timescale 1ns/1ps
`default_nettype none
module twrt_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic scl_drv_oe,
	input wire logic sda_drv_oe,
	input wire logic sda_tgt_oe,
	input wire logic scl,
	input wire logic sda
);
	logic scl_ff, sda_ff, frame_ff, nxt_frame, start_c, stop_c;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	assign start_c = scl & scl_ff & sda_ff & ~sda;
	assign stop_c = scl & scl_ff & ~sda_ff & sda;
	assign nxt_frame = start_c | (frame_ff & ~stop_c);

	// idle level of the wires, so no false start after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_ff <= 1'b1;
			sda_ff <= 1'b1;
			frame_ff <= 1'b0;
		end else begin
			scl_ff <= scl;
			sda_ff <= sda;
			frame_ff <= nxt_frame;
		end
	end

	a_tgt_hold_high: assert property (
		scl && $past(scl) |-> $stable(sda_tgt_oe))
		else $error("target sda moved while scl high");
	a_scl_low_min: assert property ($fell(scl) |-> !scl[*8])
		else $error("scl low phase too short");
	a_ack_on_low: assert property (
		$rose(sda_tgt_oe) |-> !scl && !$past(scl))
		else $error("target pulled sda outside scl low");
	a_start_by_host: assert property (
		start_c |-> sda_drv_oe && !sda_tgt_oe)
		else $error("start not made by host");
	a_stop_quiet: assert property (stop_c |=> !sda_tgt_oe[*8])
		else $error("target drives after stop");
	a_start_aborts: assert property (
		start_c |-> !sda_tgt_oe ##1 !sda_tgt_oe[*8])
		else $error("target drives right after start");
	a_tgt_in_frame: assert property (sda_tgt_oe |-> frame_ff)
		else $error("target drives outside a frame");
	a_tgt_bounded: assert property (
		$rose(sda_tgt_oe) |-> ##[1:1000] !sda_tgt_oe)
		else $error("target holds sda too long");
	a_data_early: assert property (
		$fell(scl) |-> ##4 $stable(sda_tgt_oe)[*8])
		else $error("target sda late after scl fall");

	c_ack: cover property ($rose(sda_tgt_oe));
	c_stop: cover property (stop_c);
	c_restart: cover property (start_c && frame_ff);
endmodule : twrt_chk
`default_nettype wire

// [verif/two_wire_register_target_test.sv]
/* self-checking bench: apb-driven host against the target.
   assumes the twrt rtl and twrt_chk are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module two_wire_register_target_test;
	import twrt_pkg::*;
	typedef struct packed {
		logic        err;
		logic [31:0] msk;
		logic [31:0] exp;
	} twrt_note_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        addr_sel, fw_req, fw_wr, fw_pend, busy;
	logic [7:0]  paddr;
	logic [6:0]  fw_addr;
	logic [31:0] pwdata, prdata, seed, rd;
	twrt_byte_t  status_a, status_b, fw_wdata, fw_rdata, page_control, v1;
	twrt_note_t  apb_q[$];
	twrt_byte_t  fw_q[$];
	int          failures, cmp_count;

	twrt_if twrt_if_inst ();
	twrt_target twrt_target_inst (.pclk(pclk), .presetn(presetn),
		.bus(twrt_if_inst), .status_a(status_a), .status_b(status_b),
		.addr_sel(addr_sel), .fw_req(fw_req), .fw_wr(fw_wr),
		.fw_addr(fw_addr), .fw_wdata(fw_wdata), .fw_rdata(fw_rdata),
		.page_control(page_control), .busy(busy));
	twrt_host twrt_host_inst (.pclk(pclk), .presetn(presetn),
		.bus(twrt_if_inst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	twrt_chk twrt_chk_inst (.pclk(pclk), .presetn(presetn),
		.scl_drv_oe(twrt_if_inst.scl_drv_oe),
		.sda_drv_oe(twrt_if_inst.sda_drv_oe),
		.sda_tgt_oe(twrt_if_inst.sda_tgt_oe),
		.scl(twrt_if_inst.scl), .sda(twrt_if_inst.sda));

	always #12.5 pclk = ~pclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [32:0] e,
			input logic [32:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// apb master; one idle edge between transfers keeps drives single
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d, input logic [31:0] m,
			input logic [31:0] e, input logic er);
		int n;
		apb_q.push_back('{er, m, e});
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			summarize();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic st(input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, H_STAT, 32'h0, m, e, 1'b0);
	endtask : st

	task automatic idle();
		int n;
		n = 0;
		do begin
			st(32'h0, 32'h0);
			n++;
		end while (rd[ST_BUSY] !== 1'b0 && n < 300);
		if (n >= 300) begin
			failures++;
			summarize();
		end
	endtask : idle

	task automatic cmd(input twrt_cmd_t c);
		idle();
		apb(1'b1, H_CMD, {29'h0, c}, 32'h0, 32'h0, 1'b0);
	endtask : cmd

	task automatic wb(input twrt_byte_t b, input logic ack);
		apb(1'b1, H_TXD, {24'h0, b}, 32'h0, 32'h0, 1'b0);
		cmd(CMD_WRITE);
		idle();
		st(32'h2, {30'h0, ack, 1'b0});
	endtask : wb

	task automatic wframe(input twrt_byte_t b[$]);
		cmd(CMD_START);
		wb(8'hd0, 1'b1);
		chk("busy", 33'h1, {32'h0, busy});
		foreach (b[i]) wb(b[i], 1'b1);
		cmd(CMD_STOP);
		idle();
		chk("busy", 33'h0, {32'h0, busy});
	endtask : wframe

	task automatic rframe(input twrt_byte_t dev, input twrt_byte_t r,
			input twrt_byte_t e[$]);
		cmd(CMD_START);
		wb(dev, 1'b1);
		wb(r, 1'b1);
		cmd(CMD_START);
		wb(dev | 8'h01, 1'b1);
		foreach (e[i]) begin
			cmd(i == e.size() - 1 ? CMD_READ_NACK : CMD_READ_ACK);
			idle();
			st(32'hff00, {16'h0, e[i], 8'h0});
		end
		cmd(CMD_STOP);
		idle();
	endtask : rframe

	// for reads d is the expected byte
	task automatic fw(input logic w, input logic [6:0] a, input twrt_byte_t d);
		@(posedge pclk);
		fw_req <= 1'b1;
		fw_wr <= w;
		fw_addr <= a;
		fw_wdata <= d;
		if (!w) fw_q.push_back(d);
		@(posedge pclk);
		fw_req <= 1'b0;
	endtask : fw

	always @(posedge pclk) begin
		twrt_note_t n;
		if (psel && penable && pready && apb_q.size() > 0) begin
			n = apb_q.pop_front();
			chk("apb", {n.err, n.exp}, {pslverr, prdata & n.msk});
		end
		if (fw_pend && fw_q.size() > 0) begin
			chk("fw_rdata", {25'h0, fw_q.pop_front()}, {25'h0, fw_rdata});
		end
		fw_pend <= fw_req & ~fw_wr;
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		fw_req = 1'b0;
		fw_wr = 1'b0;
		fw_addr = 7'h0;
		fw_wdata = 8'h0;
		addr_sel = 1'b0;
		status_a = 8'h0;
		status_b = 8'h0;
		seed = 32'd85454;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1'b0, 8'h0c, 32'h0, 32'h0, 32'h0, 1'b1);
		fw(1'b0, 7'h00, PAGE_RST);
		repeat (2) begin
			seed = xs(seed);
			status_a <= seed[7:0];
			status_b <= seed[15:8];
			fw(1'b0, 7'h50, seed[7:0]);
			fw(1'b0, 7'h51, seed[15:8]);
		end
		rframe(8'hd0, 8'h50, '{seed[7:0], seed[15:8], 8'h00});
		wframe('{8'h00, 8'h03});
		chk("page_control", 33'h03, {25'h0, page_control});
		rframe(8'hd0, 8'h05, '{CFG1_RST, CFG2_RST});
		rframe(8'hd0, 8'h48, '{ALT_RST, 8'h00});
		seed = xs(seed);
		v1 = seed[23:16] & 8'hf0;
		wframe('{8'h48, v1, 8'h5a});
		rframe(8'hd0, 8'h48, '{v1, 8'h00});
		fw(1'b0, 7'h48, 8'h00);
		wframe('{8'h00, 8'h42});
		v1 = v1 ^ 8'h30;
		wframe('{8'h05, 8'hd0, 8'h48, v1});
		fw(1'b0, 7'h48, v1);
		fw(1'b1, 7'h00, 8'h01);
		fw(1'b0, 7'h00, 8'h01);
		fw(1'b1, 7'h00, 8'h04);
		fw(1'b0, 7'h00, 8'h04);
		fw(1'b1, 7'h00, 8'h82);
		rframe(8'hd0, 8'h48, '{v1});
		chk("page_control", 33'h80, {25'h0, page_control});
		fw(1'b1, 7'h00, 8'h02);
		fw(1'b1, 7'h48, 8'h91);
		addr_sel <= 1'b1;
		repeat (4) @(posedge pclk);
		cmd(CMD_START);
		wb(8'hd0, 1'b0);
		cmd(CMD_STOP);
		rframe(8'h90, 8'h48, '{8'h91});
		fw(1'b1, 7'h06, 8'h00);
		cmd(CMD_START);
		wb(8'h90, 1'b0);
		chk("busy", 33'h0, {32'h0, busy});
		cmd(CMD_STOP);
		idle();
		summarize();
	end
endmodule : two_wire_register_target_test
`default_nettype wire
